// >>> verilog/sac_pkg.sv
// sac_pkg: constants for the step attenuator controller
// assumes a 100 MHz system clock and an apb register slave
package sac_pkg;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
   // link timing, figures in ns except the clock ceiling in MHz
   localparam int unsigned T_SCLK_HI_NS  = 20;
   localparam int unsigned T_SCLK_LO_NS  = 20;
   localparam int unsigned T_SCLK_MAX_MHZ = 25;
   localparam int unsigned T_LAST_LE_NS  = 10;
   localparam int unsigned T_LE_PULSE_NS = 10;
   localparam int unsigned T_SPS_NS      = 100;
   localparam int unsigned T_PDS_NS      = 10;
   // least times round up
   localparam int unsigned CYC_SCLK_HI   = (T_SCLK_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_SCLK_LO   = (T_SCLK_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_SCLK_PER  = (1000 / T_SCLK_MAX_MHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_LAST_LE   = (T_LAST_LE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_LE_PULSE  = (T_LE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_SPS       = (T_SPS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYC_PDS       = (T_PDS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 8;
   // word layout
   localparam int unsigned CODE_W        = 7;
   localparam int unsigned WORD_W        = 8;
   localparam int unsigned BITCNT_W      = 4;
   localparam logic [6:0]  CODE_MAX      = 7'h7f;
   // register offsets
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_CODE      = 12'h004;
   localparam logic [11:0] OFS_STAT      = 12'h008;
   localparam logic [11:0] OFS_LAST      = 12'h00c;
   // ctrl fields
   localparam int unsigned CTRL_SERIAL   = 0;
   localparam int unsigned CTRL_LATCHED  = 1;
   localparam int unsigned CTRL_GO       = 2;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   // stat fields
   localparam int unsigned STAT_BUSY     = 0;
   localparam int unsigned STAT_DONE     = 1;
   localparam int unsigned STAT_MODE     = 2;

   typedef enum logic [2:0] {
      SAC_IDLE, SAC_SW_WAIT, SAC_SH_LO, SAC_SH_HI, SAC_LE_WAIT, SAC_LE_HI, SAC_PDS
   } sac_state_t;
endpackage : sac_pkg

// >>> verilog/sac_apb_regs.sv
// sac_apb_regs: apb slave holding the controller's own registers
// assumes a synchronous active-high reset and a zero-wait master
`default_nettype none
module sac_apb_regs (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // apb
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // to the engine
   output logic             o_serial,
   output logic             o_latched,
   output logic      [6:0]  o_code,
   output logic             o_go,
   // from the engine
   input  wire logic        i_busy,
   input  wire logic        i_done,
   input  wire logic [6:0]  i_last
);
   typedef struct packed {
      logic        serial;
      logic        latched;
      logic [6:0]  code;
      logic        go;
      logic        done;
      logic [31:0] rdata;
      logic        err;
   } sac_regs_t;
   sac_regs_t s_reg, s_next;
   logic acc;
   logic wr;

   always_comb begin
      acc    = i_psel && i_penable;
      wr     = acc && i_pwrite;
      s_next = s_reg;
      s_next.go  = 1'b0;
      s_next.err = 1'b0;
      // set wins over the clear on done
      if (i_done) begin
         s_next.done = 1'b1;
      end else if (wr && i_paddr == sac_pkg::OFS_STAT && i_pwdata[sac_pkg::STAT_DONE]) begin
         s_next.done = 1'b0;
      end
      if (wr) begin
         case (i_paddr)
            sac_pkg::OFS_CTRL: begin
               s_next.serial  = i_pwdata[sac_pkg::CTRL_SERIAL];
               s_next.latched = i_pwdata[sac_pkg::CTRL_LATCHED];
               // go ignored while busy
               s_next.go      = i_pwdata[sac_pkg::CTRL_GO] && !i_busy;
            end
            sac_pkg::OFS_CODE: s_next.code = i_pwdata[sac_pkg::CODE_W-1:0];
            sac_pkg::OFS_STAT: ;
            sac_pkg::OFS_LAST: ;
            default: s_next.err = 1'b1;
         endcase
      end
      s_next.rdata = 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            sac_pkg::OFS_CTRL: s_next.rdata = {30'h0000_0000, s_reg.latched, s_reg.serial};
            sac_pkg::OFS_CODE: s_next.rdata = {25'h000_0000, s_reg.code};
            sac_pkg::OFS_STAT: s_next.rdata = {29'h0000_0000, s_reg.serial, s_reg.done, i_busy};
            sac_pkg::OFS_LAST: s_next.rdata = {25'h000_0000, i_last};
            default: s_next.err = 1'b1;
         endcase
      end else begin
         s_next.rdata = s_reg.rdata;
      end
      if (i_psel && !i_penable && !i_pwrite) begin
         // read miss flagged for the access phase
      end
      if (!(i_psel)) begin
         s_next.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_reg <= '{serial: 1'b0, latched: 1'b0, code: sac_pkg::CODE_MAX, go: 1'b0,
                    done: 1'b0, rdata: 32'h0000_0000, err: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_prdata  = s_reg.rdata;
   assign o_pready  = acc;
   assign o_pslverr = acc && (s_reg.err || (wr && !(i_paddr == sac_pkg::OFS_CTRL ||
                      i_paddr == sac_pkg::OFS_CODE || i_paddr == sac_pkg::OFS_STAT ||
                      i_paddr == sac_pkg::OFS_LAST)));
   assign o_serial  = s_reg.serial;
   assign o_latched = s_reg.latched;
   assign o_code    = s_reg.code;
   assign o_go      = s_reg.go;
endmodule // sac_apb_regs
`default_nettype wire

// >>> verilog/sac_sync.sv
// sac_sync: three-flop sampler for a pin from outside the clock domain
// assumes the pin may change at any time
`default_nettype none
module sac_sync (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // pin and result
   input  wire logic i_pin,
   output logic      o_level
);
   typedef struct packed {
      logic [2:0] sh;
      logic       level;
   } sac_sync_t;
   sac_sync_t s_reg, s_next;

   always_comb begin
      s_next       = s_reg;
      s_next.sh    = {s_reg.sh[1:0], i_pin};
      // first flop only feeds the second
      if (s_reg.sh[1] == s_reg.sh[2]) begin
         s_next.level = s_reg.sh[2];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_reg <= '{sh: 3'h0, level: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_level = s_reg.level;
endmodule // sac_sync
`default_nettype wire

// >>> verilog/sac_ctrl.sv
// sac_ctrl: controller driving a serial/parallel step attenuator's pins
// assumes apb software orders; the attenuator is a pin-driven part without a clock
`default_nettype none
module sac_ctrl (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // attenuator pins
   output logic             o_mode_select_pin,
   output logic             o_load_strobe,
   output logic             o_sclk,
   output logic             o_sdata,
   output logic      [6:0]  o_atten_code_bits,
   // mode pin readback from the board
   input  wire logic        i_mode_sense
);
   typedef struct packed {
      sac_pkg::sac_state_t                   st;
      logic [sac_pkg::CNT_W-1:0]             cnt;
      logic [sac_pkg::BITCNT_W-1:0]          bits;
      logic [sac_pkg::WORD_W-1:0]            shreg;
      logic                                  mode;
      logic                                  strobe;
      logic                                  sclk;
      logic                                  sdata;
      logic [sac_pkg::CODE_W-1:0]            pins;
      logic [sac_pkg::CODE_W-1:0]            last;
      logic                                  done;
   } sac_ctrl_t;
   sac_ctrl_t s_reg, s_next;

   logic                        r_serial;
   logic                        r_latched;
   logic [sac_pkg::CODE_W-1:0]  r_code;
   logic                        r_go;
   logic                        mode_lvl;

   // cycle count loaded for a timed wait, never below one
   function automatic logic [sac_pkg::CNT_W-1:0] cyc(input int unsigned n);
      cyc = (n < 1) ? sac_pkg::CNT_W'(1) : sac_pkg::CNT_W'(n);
   endfunction

   sac_apb_regs u_regs (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_psel    (i_psel),
      .i_penable (i_penable),
      .i_pwrite  (i_pwrite),
      .i_paddr   (i_paddr),
      .i_pwdata  (i_pwdata),
      .o_prdata  (o_prdata),
      .o_pready  (o_pready),
      .o_pslverr (o_pslverr),
      .o_serial  (r_serial),
      .o_latched (r_latched),
      .o_code    (r_code),
      .o_go      (r_go),
      .i_busy    (s_reg.st != sac_pkg::SAC_IDLE),
      .i_done    (s_reg.done),
      .i_last    (s_reg.last)
   );

   // board mode sense is outside our domain
   sac_sync u_mode_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_mode_sense),
      .o_level   (mode_lvl)
   );

   always_comb begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      if (s_reg.cnt != '0) begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
      case (s_reg.st)
         sac_pkg::SAC_IDLE: begin
            if (r_go) begin
               if (r_serial) begin
                  s_next.mode   = 1'b1;
                  s_next.pins   = '0;
                  s_next.strobe = 1'b0;
                  s_next.shreg  = {1'b0, r_code};
                  s_next.bits   = sac_pkg::BITCNT_W'(sac_pkg::WORD_W);
                  s_next.cnt    = cyc(sac_pkg::CYC_SCLK_LO);
                  s_next.st     = sac_pkg::SAC_SH_LO;
               end else begin
                  // leaving serial: hold off before parallel use
                  s_next.cnt    = s_reg.mode ? cyc(sac_pkg::CYC_SPS) : cyc(1);
                  s_next.mode   = 1'b0;
                  s_next.sclk   = 1'b0;
                  s_next.sdata  = 1'b0;
                  s_next.st     = sac_pkg::SAC_SW_WAIT;
               end
            end
         end
         sac_pkg::SAC_SW_WAIT: begin
            // code pins wait for the board readback to show parallel
            if (s_reg.cnt <= sac_pkg::CNT_W'(1) && !mode_lvl) begin
               if (r_latched && s_reg.strobe) begin
                  // strobe drops before the pins move, else the part follows them
                  s_next.strobe = 1'b0;
               end else if (r_latched) begin
                  s_next.pins   = r_code;
                  s_next.cnt    = cyc(sac_pkg::CYC_PDS);
                  s_next.st     = sac_pkg::SAC_PDS;
               end else begin
                  s_next.pins   = r_code;
                  s_next.strobe = 1'b1;
                  s_next.last   = r_code;
                  s_next.done   = 1'b1;
                  s_next.st     = sac_pkg::SAC_IDLE;
               end
            end
         end
         sac_pkg::SAC_PDS: begin
            if (s_reg.cnt <= sac_pkg::CNT_W'(1)) begin
               s_next.strobe = 1'b1;
               s_next.cnt    = cyc(sac_pkg::CYC_LE_PULSE);
               s_next.st     = sac_pkg::SAC_LE_HI;
            end
         end
         sac_pkg::SAC_SH_LO: begin
            // data set while clock low, lsb first
            s_next.sdata = s_reg.shreg[0];
            if (s_reg.cnt <= sac_pkg::CNT_W'(1)) begin
               s_next.sclk  = 1'b1;
               s_next.shreg = {1'b0, s_reg.shreg[sac_pkg::WORD_W-1:1]};
               s_next.bits  = s_reg.bits - 1'b1;
               // period also honours the 25 MHz ceiling
               s_next.cnt   = cyc((sac_pkg::CYC_SCLK_HI > sac_pkg::CYC_SCLK_PER - sac_pkg::CYC_SCLK_LO) ?
                              sac_pkg::CYC_SCLK_HI : sac_pkg::CYC_SCLK_PER - sac_pkg::CYC_SCLK_LO);
               s_next.st    = sac_pkg::SAC_SH_HI;
            end
         end
         sac_pkg::SAC_SH_HI: begin
            if (s_reg.cnt <= sac_pkg::CNT_W'(1)) begin
               s_next.sclk = 1'b0;
               if (s_reg.bits == '0) begin
                  s_next.cnt = cyc(sac_pkg::CYC_LAST_LE);
                  s_next.st  = sac_pkg::SAC_LE_WAIT;
               end else begin
                  s_next.cnt = cyc(sac_pkg::CYC_SCLK_LO);
                  s_next.st  = sac_pkg::SAC_SH_LO;
               end
            end
         end
         sac_pkg::SAC_LE_WAIT: begin
            // counted from the last falling clock edge, no clock until strobe
            if (s_reg.cnt <= sac_pkg::CNT_W'(1)) begin
               s_next.strobe = 1'b1;
               s_next.cnt    = cyc(sac_pkg::CYC_LE_PULSE);
               s_next.st     = sac_pkg::SAC_LE_HI;
            end
         end
         sac_pkg::SAC_LE_HI: begin
            if (s_reg.cnt <= sac_pkg::CNT_W'(1)) begin
               // strobe back low; held parallel state stays put
               s_next.strobe = 1'b0;
               s_next.sdata  = 1'b0;
               s_next.last   = s_reg.mode ? r_code : s_reg.pins;
               s_next.done   = 1'b1;
               s_next.st     = sac_pkg::SAC_IDLE;
            end
         end
         default: s_next.st = sac_pkg::SAC_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         // pins low at start; part sits at max attenuation from power-up
         s_reg <= '{st: sac_pkg::SAC_IDLE, cnt: '0, bits: '0, shreg: '0, mode: 1'b0,
                    strobe: 1'b0, sclk: 1'b0, sdata: 1'b0, pins: '0,
                    last: sac_pkg::CODE_MAX, done: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_mode_select_pin = s_reg.mode;
   assign o_load_strobe     = s_reg.strobe;
   assign o_sclk            = s_reg.sclk;
   assign o_sdata           = s_reg.sdata;
   assign o_atten_code_bits = s_reg.pins;
endmodule // sac_ctrl
`default_nettype wire

// >>> test/sac_ctrl_properties.sv
// sac_ctrl_props: pin-level timing checks on the attenuator controller
// assumes it is bound to sac_ctrl and sees only that module's ports
`default_nettype none
module sac_ctrl_props (
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   // attenuator pins
   input wire logic       o_mode_select_pin,
   input wire logic       o_load_strobe,
   input wire logic       o_sclk,
   input wire logic       o_sdata,
   input wire logic [6:0] o_atten_code_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   code_pins_quiet_a: assert property (o_mode_select_pin |-> o_atten_code_bits == 7'h00)
      else $error("code pins driven during serial loading");
   strobe_low_shift_a: assert property ($rose(o_sclk) |-> !o_load_strobe)
      else $error("strobe high at a serial clock rise");
   strobe_no_clk_a: assert property (o_load_strobe |-> !$rose(o_sclk))
      else $error("serial clock rose while strobe high");
   sclk_high_a: assert property ($rose(o_sclk) |=> o_sclk)
      else $error("serial clock high phase under 20 ns");
   sclk_low_a: assert property ($fell(o_sclk) |=> !o_sclk)
      else $error("serial clock low phase under 20 ns");
   sclk_rate_a: assert property ($rose(o_sclk) |=> !$rose(o_sclk) [*3])
      else $error("serial clock period under 40 ns");
   data_window_a: assert property ($rose(o_sclk) |-> $stable(o_sdata) ##1 $stable(o_sdata))
      else $error("serial data moved around clock rise");
   mode_settle_a: assert property ($fell(o_mode_select_pin) |-> !$rose(o_load_strobe) [*8] ##1 !$rose(o_load_strobe) [*2])
      else $error("strobe used within 100 ns of leaving serial mode");
   par_quiet_a: assert property (!o_mode_select_pin |-> !o_sclk && !o_sdata)
      else $error("serial lines active in parallel mode");
endmodule // sac_ctrl_props
bind sac_ctrl sac_ctrl_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_mode_select_pin(o_mode_select_pin),
   .o_load_strobe(o_load_strobe), .o_sclk(o_sclk), .o_sdata(o_sdata), .o_atten_code_bits(o_atten_code_bits));
`default_nettype wire

// >>> test/sac_atten_model.sv
// sac_atten_model: behavioural step attenuator seen at its control pins
// assumes pins driven by the controller; no clock of its own
`default_nettype none
module sac_atten_model (
   // control pins
   input wire logic       i_mode_select_pin,
   input wire logic       i_load_strobe,
   input wire logic       i_sclk,
   input wire logic       i_sdata,
   input wire logic [6:0] i_atten_code_bits,
   // applied code, bit n weighs 0.25 dB times 2**n
   output logic     [6:0] o_atten
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift_reg;
   initial begin
      shift_reg = 8'hff;
      o_atten = 7'h7f;
   end
   // keeps last eight bits; first bit ends at bit 0; serial lines ignored in parallel
   always @(posedge i_sclk) begin
      if (i_mode_select_pin) shift_reg <= {i_sdata, shift_reg[7:1]};
   end
   always @(posedge i_load_strobe) begin
      if (i_mode_select_pin) o_atten <= shift_reg[6:0];
      else o_atten <= i_atten_code_bits;
   end
   // transparent only while strobe high, so a falling strobe holds the state
   always @(i_atten_code_bits, i_mode_select_pin, i_load_strobe) begin
      if (!i_mode_select_pin && i_load_strobe) o_atten <= i_atten_code_bits;
   end
endmodule // sac_atten_model
`default_nettype wire

// >>> test/tb_sac_ctrl.sv
// tb_sac_ctrl: apb-driven bench for the attenuator controller
// assumes sac_ctrl with zero-wait apb and the behavioural attenuator model
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_sac_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [31:0] o_prdata;
   logic        o_pready;
   logic        o_pslverr;
   logic        o_mode_select_pin;
   logic        o_load_strobe;
   logic        o_sclk;
   logic        o_sdata;
   logic [6:0]  o_atten_code_bits;
   logic [6:0]  atten;
   logic [31:0] rd;
   logic        err;
   logic [6:0]  prev;
   logic [6:0]  codes [10] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h7f, 7'h00, 7'h55};
   int          fail_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #5 i_clk = ~i_clk;
   sac_ctrl u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_mode_select_pin(o_mode_select_pin), .o_load_strobe(o_load_strobe),
      .o_sclk(o_sclk), .o_sdata(o_sdata), .o_atten_code_bits(o_atten_code_bits),
      .i_mode_sense(o_mode_select_pin));
   sac_atten_model u_dev (.i_mode_select_pin(o_mode_select_pin), .i_load_strobe(o_load_strobe),
      .i_sclk(o_sclk), .i_sdata(o_sdata), .i_atten_code_bits(o_atten_code_bits), .o_atten(atten));
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic start(input logic [31:0] ctrl, input logic [6:0] code);
      apb(1'b1, sac_pkg::OFS_CODE, {25'h0, code});
      apb(1'b1, sac_pkg::OFS_CTRL, ctrl);
   endtask
   // polls done, then clears it
   task automatic wait_done;
      int n;
      n = 0;
      rd = 32'h0000_0000;
      while (rd[sac_pkg::STAT_DONE] !== 1'b1 && n < 200) begin
         apb(1'b0, sac_pkg::OFS_STAT, 32'h0000_0000);
         n++;
      end
      `CHK("job done", 1'b1, rd[sac_pkg::STAT_DONE])
      apb(1'b1, sac_pkg::OFS_STAT, 32'h0000_0002);
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("ERROR timeout expected finish seen hang");
         final_report();
      end
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      apb(1'b0, sac_pkg::OFS_CODE, 32'h0000_0000);
      `CHK("code reset", 32'h0000_007f, rd)
      apb(1'b0, sac_pkg::OFS_LAST, 32'h0000_0000);
      `CHK("last reset", 32'h0000_007f, rd)
      `CHK("power-up atten", 7'h7f, atten)
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      apb(1'b1, 12'h010, 32'h0000_0000);
      `CHK("unmapped write err", 1'b1, err)
      prev = 7'h7f;
      foreach (codes[i]) begin
         start(32'h0000_0005, codes[i]);
         repeat (12) @(posedge i_clk);
         `CHK("atten mid-shift", prev, atten)
         `CHK("serial mode pin", 1'b1, o_mode_select_pin)
         apb(1'b0, sac_pkg::OFS_STAT, 32'h0000_0000);
         `CHK("busy mid-shift", 1'b1, rd[sac_pkg::STAT_BUSY])
         wait_done();
         `CHK("serial atten", codes[i], atten)
         apb(1'b0, sac_pkg::OFS_LAST, 32'h0000_0000);
         `CHK("last code", {25'h0, codes[i]}, rd)
         prev = codes[i];
      end
      apb(1'b0, sac_pkg::OFS_STAT, 32'h0000_0000);
      `CHK("stat serial", 1'b1, rd[sac_pkg::STAT_MODE])
      start(32'h0000_0006, 7'h2a);
      wait_done();
      `CHK("latched atten", 7'h2a, atten)
      `CHK("parallel mode pin", 1'b0, o_mode_select_pin)
      `CHK("latched strobe low", 1'b0, o_load_strobe)
      start(32'h0000_0004, 7'h15);
      wait_done();
      `CHK("direct atten", 7'h15, atten)
      `CHK("direct strobe", 1'b1, o_load_strobe)
      start(32'h0000_0004, 7'h6b);
      wait_done();
      `CHK("direct follow", 7'h6b, atten)
      start(32'h0000_0006, 7'h33);
      wait_done();
      repeat (20) @(posedge i_clk);
      `CHK("latched hold", 7'h33, atten)
      start(32'h0000_0005, 7'h4c);
      wait_done();
      `CHK("back to serial", 7'h4c, atten)
      final_report();
   end
endmodule // tb_sac_ctrl
`undef CHK
`default_nettype wire
